// ### rtcc_pkg.sv
// rtcc_pkg: constants, types and helpers of the retimer channel control block
package rtcc_pkg;
   localparam int NCH = 8;
   localparam int NPAIR = 4;
   // address layout: bit 12 global page, bit 11 broadcast, bits 10:8 channel, bits 7:2 index
   localparam int A_GLOB = 12;
   localparam int A_BCAST = 11;
   localparam int A_CH_LSB = 8;
   // channel register indices
   localparam logic [5:0] R_CTRL = 6'h00;
   localparam logic [5:0] R_BOOST = 6'h01;
   localparam logic [5:0] R_DFE = 6'h02;
   localparam logic [5:0] R_RATE = 6'h03;
   localparam logic [5:0] R_RATE_G0 = 6'h04;
   localparam logic [5:0] R_RATE_G1 = 6'h05;
   localparam logic [5:0] R_FIR_PEND = 6'h06;
   localparam logic [5:0] R_FIR_ACT = 6'h07;
   localparam logic [5:0] R_PRBS_GEN = 6'h08;
   localparam logic [5:0] R_PRBS_CHK = 6'h09;
   localparam logic [5:0] R_PRBS_ERR = 6'h0a;
   localparam logic [5:0] R_STATUS = 6'h0b;
   // global register indices
   localparam logic [5:0] R_XP_BASE = 6'h00;
   localparam logic [5:0] R_TABLE_BASE = 6'h10;
   // control register fields
   localparam int C_MODE = 0;
   localparam int C_BOOST_OVR = 2;
   localparam int C_LIMIT = 3;
   localparam int C_VGA = 4;
   localparam int C_HIGAIN = 5;
   localparam int C_DFE_OVR = 6;
   localparam int C_DFE_CONT = 7;
   localparam int C_CDR_RST = 8;
   localparam logic [7:0] CTRL_RST = 8'h20;
   // rate register fields: [0] manual, [4:1] standard selection, [6:5] divider
   localparam int RT_MAN = 0;
   localparam int RT_SEL = 1;
   localparam int RT_DIV = 5;
   localparam logic [3:0] RATE_STD_25G78 = 4'h0;
   localparam logic [23:0] RATE_GRP_RST = 24'h000000;
   // prbs fields and the cross-point source select bit
   localparam int G_PAT = 0;
   localparam int G_INV = 2;
   localparam int G_EN = 3;
   localparam int K_EN = 0;
   localparam int K_CLR = 1;
   localparam int K_RST = 2;
   localparam int K_PAT = 3;
   localparam logic [30:0] PRBS_SEED = 31'h7fffffff;
   localparam logic [5:0] CHK_FILL = 6'h1f;
   localparam int XP_BSEL = 2;

   typedef enum logic [1:0] {XP_DEFAULT = 2'h0, XP_FANOUT = 2'h1, XP_CROSS = 2'h2} rtcc_xp_t;
   typedef enum logic [1:0] {PAT_P7 = 2'h0, PAT_P9 = 2'h1, PAT_P15 = 2'h2, PAT_P31 = 2'h3} rtcc_pat_t;

   typedef struct packed {
      logic [1:0] adapt_mode;
      logic boost_limit;
      logic vga_en;
      logic eq_higain;
      logic dfe_cont;
      logic [7:0] eq_boost;
      logic [29:0] dfe_taps;
      logic rate_manual;
      logic [3:0] rate_sel;
      logic [1:0] rate_div;
      logic [23:0] rate_g0;
      logic [23:0] rate_g1;
      logic [17:0] fir_taps;
   } rtcc_chcfg_t;

   // feedback bit of the selected pattern polynomial
   function automatic logic rtcc_prbs_fb(input logic [30:0] s, input logic [1:0] p);
      logic fb;
      fb = 1'b0;
      unique case (p)
         PAT_P7: fb = s[6] ^ s[5];
         PAT_P9: fb = s[8] ^ s[4];
         PAT_P15: fb = s[14] ^ s[13];
         PAT_P31: fb = s[30] ^ s[27];
      endcase
      return fb;
   endfunction
endpackage

// ### rtcc_top.sv
// rtcc_top: per-channel equalizer, rate, fir, prbs and cross-point control behind apb
`timescale 1ns/100ps
`default_nettype none
module rtcc_top
   import rtcc_pkg::*;
#(
   parameter int ERR_W = 16
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [12:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [NCH-1:0] RX_DATA,
   input wire logic [NCH-1:0] SIG_DET,
   input wire logic [NCH-1:0] CDR_LOCK,
   input wire logic [NCH-1:0][7:0] ADAPT_BOOST,
   input wire logic [NCH-1:0][29:0] ADAPT_DFE,
   output logic [NCH-1:0] TX_DATA,
   output rtcc_chcfg_t [NCH-1:0] CH_CFG,
   output logic [NCH-1:0] CDR_RST,
   output logic [15:0][7:0] BOOST_TABLE
);
   logic [5:0] idx;
   logic [2:0] chn;
   logic setup, wr, map_ok;
   logic [NCH-1:0] chw;
   logic [31:0] rd;
   logic [7:0] ctrl_q [NCH];
   logic [7:0] boost_man_q [NCH];
   logic [29:0] dfe_man_q [NCH];
   logic [6:0] rate_q [NCH];
   logic [23:0] g0_q [NCH];
   logic [23:0] g1_q [NCH];
   logic [17:0] fir_pend_q [NCH];
   logic [17:0] fir_act_q [NCH];
   logic [3:0] gen_q [NCH];
   logic [30:0] gen_st_q [NCH];
   logic [2:0] chk_q [NCH];
   logic [30:0] chk_st_q [NCH];
   logic [5:0] fill_q [NCH];
   logic [ERR_W-1:0] err_q [NCH];
   logic [2:0] xp_q [NPAIR];
   logic [7:0] table_q [16];
   logic [NCH-1:0] gfb, cfb, cerr, src, tx_d;
   logic [3*NCH-1:0] s1_q, s2_q, s3_q, flt_q;
   logic [NCH-1:0] rx_f, sd_f, lock_f;
   rtcc_chcfg_t [NCH-1:0] cfg_d;

   assign idx = PADDR[7:2];
   assign chn = PADDR[A_CH_LSB+2:A_CH_LSB];
   assign setup = PSEL & ~PENABLE;
   assign wr = PSEL & PENABLE & PREADY & PWRITE & map_ok;

   // broadcast reads have no single source, so they are refused
   always_comb begin
      if (PADDR[A_GLOB]) begin
         map_ok = (idx < 6'(NPAIR)) || (idx[5:4] == 2'b01);
      end else begin
         map_ok = (idx <= R_STATUS) && (PWRITE || !PADDR[A_BCAST]);
      end
   end

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         chw[c] = wr && !PADDR[A_GLOB] && (PADDR[A_BCAST] || chn == 3'(c));
      end
   end

   // pin inputs: three stages, a change counts once stages two and three agree
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         flt_q <= '0;
      end else begin
         s1_q <= {CDR_LOCK, SIG_DET, RX_DATA};
         s2_q <= s1_q;
         s3_q <= s2_q;
         flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
      end
   end
   assign rx_f = flt_q[NCH-1:0];
   assign sd_f = flt_q[2*NCH-1:NCH];
   assign lock_f = flt_q[3*NCH-1:2*NCH];

   // read data is formed in the setup cycle, so the slave never waits
   always_comb begin
      rd = '0;
      if (PADDR[A_GLOB]) begin
         if (idx[5:4] == 2'b01) begin
            rd[7:0] = table_q[idx[3:0]];
         end else if (idx < 6'(NPAIR)) begin
            rd[2:0] = xp_q[idx[1:0]];
         end
      end else begin
         unique case (idx)
            R_CTRL: rd[7:0] = ctrl_q[chn];
            R_BOOST: rd[7:0] = CH_CFG[chn].eq_boost;
            R_DFE: rd[29:0] = CH_CFG[chn].dfe_taps;
            R_RATE: rd[6:0] = rate_q[chn];
            R_RATE_G0: rd[23:0] = g0_q[chn];
            R_RATE_G1: rd[23:0] = g1_q[chn];
            R_FIR_PEND: rd[17:0] = fir_pend_q[chn];
            R_FIR_ACT: rd[17:0] = fir_act_q[chn];
            R_PRBS_GEN: rd[3:0] = gen_q[chn];
            R_PRBS_CHK: rd[4:0] = {chk_q[chn][2:1], 2'b00, chk_q[chn][0]};
            R_PRBS_ERR: rd[ERR_W-1:0] = err_q[chn];
            R_STATUS: rd[1:0] = {lock_f[chn], sd_f[chn]};
            default: rd = '0;
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= setup;
         if (setup) begin
            PRDATA <= PWRITE ? 32'h0 : rd;
            PSLVERR <= !map_ok;
         end
      end
   end

   // equalizer controls
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int c = 0; c < NCH; c++) begin
            ctrl_q[c] <= CTRL_RST;
            boost_man_q[c] <= '0;
            dfe_man_q[c] <= '0;
            CDR_RST[c] <= 1'b0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            CDR_RST[c] <= chw[c] && idx == R_CTRL && PWDATA[C_CDR_RST];
            if (chw[c] && idx == R_CTRL) ctrl_q[c] <= PWDATA[7:0];
            if (chw[c] && idx == R_BOOST) boost_man_q[c] <= PWDATA[7:0];
            if (chw[c] && idx == R_DFE) dfe_man_q[c] <= PWDATA[29:0];
         end
      end
   end

   // rate configuration
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int c = 0; c < NCH; c++) begin
            rate_q[c] <= {2'b00, RATE_STD_25G78, 1'b0};
            g0_q[c] <= RATE_GRP_RST;
            g1_q[c] <= RATE_GRP_RST;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (chw[c] && idx == R_RATE) rate_q[c] <= PWDATA[6:0];
            if (chw[c] && idx == R_RATE_G0) g0_q[c] <= PWDATA[23:0];
            if (chw[c] && idx == R_RATE_G1) g1_q[c] <= PWDATA[23:0];
         end
      end
   end

   // fir taps: staged, then applied together so no half-updated set reaches the driver
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int c = 0; c < NCH; c++) begin
            fir_pend_q[c] <= '0;
            fir_act_q[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (chw[c] && idx == R_FIR_PEND) fir_pend_q[c] <= PWDATA[17:0];
            if (chw[c] && idx == R_FIR_ACT && PWDATA[0]) fir_act_q[c] <= fir_pend_q[c];
         end
      end
   end

   // global page: cross-point pairs and boost table
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int p = 0; p < NPAIR; p++) xp_q[p] <= {1'b0, XP_DEFAULT};
         for (int t = 0; t < 16; t++) table_q[t] <= '0;
      end else if (wr && PADDR[A_GLOB]) begin
         if (idx < 6'(NPAIR)) xp_q[idx[1:0]] <= PWDATA[2:0];
         if (idx[5:4] == 2'b01) table_q[idx[3:0]] <= PWDATA[7:0];
      end
   end

   // effective channel configuration
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         cfg_d[c].adapt_mode = ctrl_q[c][C_MODE+1:C_MODE];
         cfg_d[c].boost_limit = ctrl_q[c][C_LIMIT];
         cfg_d[c].vga_en = ctrl_q[c][C_VGA];
         cfg_d[c].eq_higain = ctrl_q[c][C_HIGAIN];
         cfg_d[c].dfe_cont = ctrl_q[c][C_DFE_CONT];
         // manual boost only in mode 0
         cfg_d[c].eq_boost = (ctrl_q[c][C_MODE+1:C_MODE] == 2'b00 && ctrl_q[c][C_BOOST_OVR]) ?
                             boost_man_q[c] : ADAPT_BOOST[c];
         cfg_d[c].dfe_taps = ctrl_q[c][C_DFE_OVR] ? dfe_man_q[c] : ADAPT_DFE[c];
         cfg_d[c].rate_manual = rate_q[c][RT_MAN];
         cfg_d[c].rate_sel = rate_q[c][RT_SEL+3:RT_SEL];
         cfg_d[c].rate_div = rate_q[c][RT_DIV+1:RT_DIV];
         cfg_d[c].rate_g0 = g0_q[c];
         cfg_d[c].rate_g1 = g1_q[c];
         cfg_d[c].fir_taps = fir_act_q[c];
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CH_CFG <= '0;
         BOOST_TABLE <= '0;
      end else begin
         CH_CFG <= cfg_d;
         for (int t = 0; t < 16; t++) BOOST_TABLE[t] <= table_q[t];
      end
   end

   // prbs generator
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int c = 0; c < NCH; c++) begin
            gen_q[c] <= '0;
            gen_st_q[c] <= PRBS_SEED;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (chw[c] && idx == R_PRBS_GEN) gen_q[c] <= PWDATA[3:0];
            if (gen_q[c][G_EN]) gen_st_q[c] <= {gen_st_q[c][29:0], gfb[c]};
            else gen_st_q[c] <= PRBS_SEED;
         end
      end
   end

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         gfb[c] = rtcc_prbs_fb(gen_st_q[c], gen_q[c][G_PAT+1:G_PAT]);
         src[c] = gen_q[c][G_EN] ? (gfb[c] ^ gen_q[c][G_INV]) : rx_f[c];
         cfb[c] = rtcc_prbs_fb(chk_st_q[c], chk_q[c][K_PAT-1:K_PAT-2]);
         cerr[c] = chk_q[c][K_EN] && fill_q[c] == CHK_FILL && rx_f[c] != cfb[c];
      end
   end

   // prbs checker; errors ignored until the shift register holds a full pattern state
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int c = 0; c < NCH; c++) begin
            chk_q[c] <= '0;
            chk_st_q[c] <= '0;
            fill_q[c] <= '0;
            err_q[c] <= '0;
         end
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (chw[c] && idx == R_PRBS_CHK && (!PWDATA[K_EN] || PWDATA[K_RST])) begin
               chk_q[c] <= PWDATA[K_EN] ? {PWDATA[K_PAT+1:K_PAT], 1'b1} : 3'h0;
               chk_st_q[c] <= '0;
               fill_q[c] <= '0;
               err_q[c] <= '0;
            end else begin
               if (chw[c] && idx == R_PRBS_CHK) chk_q[c] <= {PWDATA[K_PAT+1:K_PAT], 1'b1};
               if (chk_q[c][K_EN]) begin
                  chk_st_q[c] <= {chk_st_q[c][29:0], rx_f[c]};
                  if (fill_q[c] != CHK_FILL) fill_q[c] <= fill_q[c] + 6'h01;
               end
               // clear counter only; an error in that cycle still counts
               if (chw[c] && idx == R_PRBS_CHK && PWDATA[K_CLR]) begin
                  err_q[c] <= ERR_W'(cerr[c]);
               end else if (cerr[c] && err_q[c] != '1) begin
                  err_q[c] <= err_q[c] + ERR_W'(1);
               end
            end
         end
      end
   end

   // cross-point selection
   always_comb begin
      for (int p = 0; p < NPAIR; p++) begin
         unique case (xp_q[p][1:0])
            XP_FANOUT: begin
               tx_d[2*p] = src[2*p+int'(xp_q[p][XP_BSEL])];
               tx_d[2*p+1] = src[2*p+int'(xp_q[p][XP_BSEL])];
            end
            XP_CROSS: begin
               tx_d[2*p] = src[2*p+1];
               tx_d[2*p+1] = src[2*p];
            end
            // own receiver, also for the unused code
            default: begin
               tx_d[2*p] = src[2*p];
               tx_d[2*p+1] = src[2*p+1];
            end
         endcase
      end
   end

   // whole pair changes on one edge
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) TX_DATA <= '0;
      else TX_DATA <= tx_d;
   end

   for (genvar p = 0; p < NPAIR; p++) begin : g_pair_chk
      xp_own_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
         xp_q[p][1:0] == XP_DEFAULT |=> TX_DATA[2*p] == $past(src[2*p]))
         else $error("default mode lost own data");
      xp_cross_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
         xp_q[p][1:0] == XP_CROSS |=> TX_DATA[2*p] == $past(src[2*p+1]) && TX_DATA[2*p+1] == $past(src[2*p]))
         else $error("lane crossing wrong");
      xp_fan_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
         xp_q[p][1:0] == XP_FANOUT |=> TX_DATA[2*p] == TX_DATA[2*p+1])
         else $error("fanout pair differs");
   end

   for (genvar c = 0; c < NCH; c++) begin : g_ch_chk
      man_boost_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
         ctrl_q[c][1:0] == 2'b00 && ctrl_q[c][C_BOOST_OVR] |=> CH_CFG[c].eq_boost == $past(boost_man_q[c]))
         else $error("manual boost not used");
      adapt_boost_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
         RST_N && !ctrl_q[c][C_BOOST_OVR] |=> CH_CFG[c].eq_boost == $past(ADAPT_BOOST[c]))
         else $error("adapted boost not used");
      dfe_ovr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
         ctrl_q[c][C_DFE_OVR] |=> CH_CFG[c].dfe_taps == $past(dfe_man_q[c]))
         else $error("dfe override ignored");
      fir_apply_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
         chw[c] && idx == R_FIR_ACT && PWDATA[0] |=> ##1 CH_CFG[c].fir_taps == $past(fir_pend_q[c], 2))
         else $error("fir apply missed");
      err_sat_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
         err_q[c] == '1 && !chw[c] |=> err_q[c] == '1)
         else $error("error counter wrapped");
      cdr_pulse_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
         CDR_RST[c] |=> !CDR_RST[c])
         else $error("cdr reset not a pulse");
   end

   bcast_wr_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      wr && !PADDR[A_GLOB] && PADDR[A_BCAST] && idx == R_CTRL |=> ctrl_q[0] == ctrl_q[NCH-1])
      else $error("broadcast did not reach all channels");
endmodule
`default_nettype wire

// ### rtcc_link_model.sv
// rtcc_link_model: serial link partner feeding recovered data, status and adapted eq
`timescale 1ns/100ps
`default_nettype none
module rtcc_link_model
   import rtcc_pkg::*;
(
   input wire logic clk,
   input wire logic rnd_en,
   input wire logic [NCH-1:0] word,
   input wire logic [NCH-1:0] sd,
   input wire logic [NCH-1:0] lk,
   output logic [NCH-1:0] rx_data,
   output logic [NCH-1:0] sig_det,
   output logic [NCH-1:0] cdr_lock,
   output logic [NCH-1:0][7:0] adapt_boost,
   output logic [NCH-1:0][29:0] adapt_dfe
);
   // random bits stress the checker; a held word lets the cross-point settle
   always_ff @(posedge clk) begin
      rx_data <= rnd_en ? NCH'($urandom) : word;
   end
   always_ff @(posedge clk) begin
      sig_det <= sd;
      cdr_lock <= lk;
   end
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         adapt_boost[c] = 8'h1b ^ 8'(c);
         adapt_dfe[c] = 30'h2a5c3e1 ^ 30'(c);
      end
   end
endmodule
`default_nettype wire

// ### tb_retimer_channel_control.sv
// tb_retimer_channel_control: apb bench with reference model of the channel control
`timescale 1ns/100ps
`default_nettype none
module tb_retimer_channel_control
   import rtcc_pkg::*;
;
   localparam int EW = 4;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rnd_en = 0;
   logic [12:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [NCH-1:0] word = '0, sd = '0, lk = '0, rx, sdet, lock, tx, cdr_rst;
   logic [NCH-1:0][7:0] ab;
   logic [NCH-1:0][29:0] ad;
   rtcc_chcfg_t [NCH-1:0] cfg;
   logic [15:0][7:0] btab;
   int n_mismatch = 0, total_checks = 0;
   int rst_cnt[NCH];
   int m_reg[NCH][16];

   rtcc_top #(.ERR_W(EW)) DUT (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RX_DATA(rx),
      .SIG_DET(sdet), .CDR_LOCK(lock), .ADAPT_BOOST(ab), .ADAPT_DFE(ad), .TX_DATA(tx), .CH_CFG(cfg),
      .CDR_RST(cdr_rst), .BOOST_TABLE(btab));
   rtcc_link_model LP (.clk(clk), .rnd_en(rnd_en), .word(word), .sd(sd), .lk(lk), .rx_data(rx),
      .sig_det(sdet), .cdr_lock(lock), .adapt_boost(ab), .adapt_dfe(ad));

   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      for (int c = 0; c < NCH; c++) if (cdr_rst[c] === 1'b1) rst_cnt[c]++;
   end

   function automatic logic [12:0] ca(input int c, input int i);
      return 13'(c * 256 + i * 4);
   endfunction
   function automatic logic [12:0] ga(input int i);
      return 13'h1000 | 13'(i * 4);
   endfunction
   // readable bits of each channel register the model tracks
   function automatic logic [31:0] msk(input int i);
      case (i)
         0: return 32'hff;
         3: return 32'h7f;
         4, 5: return 32'hffffff;
         6: return 32'h3ffff;
         8: return 32'hf;
         default: return 32'h0;
      endcase
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      chk("pready_wait", 32'h1, n);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdv(input logic [12:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk($sformatf("rdata_%h", a), x, r);
      chk("slverr", 32'h0, {31'h0, e});
   endtask
   // negative channel means broadcast to all channels
   task automatic wch(input int c, input int i, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, c < 0 ? 13'h800 | 13'(i * 4) : ca(c, i), d, r, e);
      chk("wr_err", 32'h0, {31'h0, e});
      for (int k = 0; k < NCH; k++) if (c < 0 || c == k) m_reg[k][i] = d & msk(i);
   endtask
   task automatic rch(input int c, input int i);
      rdv(ca(c, i), m_reg[c][i]);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      #2000000;
      n_mismatch++;
      end_sim();
   end

   initial begin
      logic [31:0] r, v;
      logic e;
      logic [1:0] ex;
      logic [30:0] lfsr;
      int md;
      r = $urandom(32'hce3f9b31);
      for (int k = 0; k < NCH; k++) m_reg[k][0] = 32'h20;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int k = 0; k < NCH; k++) begin
         rch(k, R_CTRL);
         rch(k, R_RATE);
         chk("higain", 32'h1, {31'h0, cfg[k].eq_higain});
         chk("rate_sel", {28'h0, RATE_STD_25G78}, {28'h0, cfg[k].rate_sel});
      end
      apb(1'b0, ca(0, 63), 32'h0, r, e);
      chk("unmapped_err", 32'h1, {31'h0, e});
      apb(1'b0, 13'h800, 32'h0, r, e);
      chk("bcast_rd_err", 32'h1, {31'h0, e});
      for (int m = 0; m < 4; m++) begin
         wch(0, R_CTRL, 32'h20 | m);
         repeat (3) @(posedge clk);
         chk("mode", m, {30'h0, cfg[0].adapt_mode});
      end
      wch(-1, R_CTRL, 32'ha2);
      wch(3, R_CTRL, 32'h21);
      repeat (3) @(posedge clk);
      for (int k = 0; k < NCH; k++) begin
         rch(k, R_CTRL);
         chk("mode", m_reg[k][0] & 3, {30'h0, cfg[k].adapt_mode});
         chk("dfe_cont", (m_reg[k][0] >> 7) & 1, {31'h0, cfg[k].dfe_cont});
      end
      chk("boost_adapt", {24'h0, ab[5]}, {24'h0, cfg[5].eq_boost});
      rst_cnt = '{default: 0};
      wch(5, R_BOOST, 32'he4);
      wch(5, R_CTRL, 32'h13c);
      repeat (3) @(posedge clk);
      chk("boost_man", 32'he4, {24'h0, cfg[5].eq_boost});
      chk("limit", 32'h1, {31'h0, cfg[5].boost_limit});
      chk("vga", 32'h1, {31'h0, cfg[5].vga_en});
      for (int k = 0; k < NCH; k++) chk("cdr_rst", k == 5, rst_cnt[k]);
      rch(5, R_CTRL);
      rdv(ca(5, R_BOOST), 32'he4);
      chk("dfe_adapt", {2'h0, ad[6]}, {2'h0, cfg[6].dfe_taps});
      v = {2'h0, 30'($urandom)};
      wch(6, R_DFE, v);
      wch(6, R_CTRL, 32'h60);
      repeat (3) @(posedge clk);
      chk("dfe_ovr", v, {2'h0, cfg[6].dfe_taps});
      rdv(ca(6, R_DFE), v);
      for (int i = 0; i < 16; i++) begin
         v = {24'h0, 8'($urandom)};
         apb(1'b1, ga(16 + i), v, r, e);
         rdv(ga(16 + i), v);
         chk("table", v, {24'h0, btab[i]});
      end
      rst_cnt = '{default: 0};
      // manual mode, divider code 1 for a mid rate
      wch(1, R_RATE, 32'h23);
      wch(1, R_RATE_G0, $urandom);
      wch(1, R_RATE_G1, $urandom);
      wch(1, R_CTRL, 32'h120);
      for (int i = 3; i < 6; i++) rch(1, i);
      chk("manual", 32'h1, {31'h0, cfg[1].rate_manual});
      chk("rate_g1", m_reg[1][5], {8'h0, cfg[1].rate_g1});
      chk("rate_div", 32'h1, {30'h0, cfg[1].rate_div});
      chk("rate_g0", m_reg[1][4], {8'h0, cfg[1].rate_g0});
      chk("cdr_rst1", 32'h1, rst_cnt[1]);
      v = {14'h0, 18'($urandom)};
      wch(2, R_FIR_PEND, v);
      rdv(ca(2, R_FIR_ACT), 32'h0);
      chk("fir_idle", 32'h0, {14'h0, cfg[2].fir_taps});
      wch(2, R_FIR_ACT, 32'h1);
      repeat (3) @(posedge clk);
      chk("fir_act", v, {14'h0, cfg[2].fir_taps});
      rdv(ca(2, R_FIR_ACT), v);
      for (int p = 0; p < 4; p++) begin
         wch(4, R_PRBS_GEN, p | 4);
         rch(4, R_PRBS_GEN);
      end
      for (int m = 0; m < 4; m++) begin
         word <= NCH'($urandom);
         for (int p = 0; p < NPAIR; p++) apb(1'b1, ga(p), (m + p) % 4 | (p & 1) << 2, r, e);
         repeat (8) @(posedge clk);
         for (int p = 0; p < NPAIR; p++) begin
            md = (m + p) % 4;
            ex = {word[2*p+1], word[2*p]};
            if (md == 1) ex = {2{word[2*p+(p&1)]}};
            if (md == 2) ex = {ex[0], ex[1]};
            chk("tx_pair", {30'h0, ex}, {30'h0, tx[2*p+1], tx[2*p]});
            rdv(ga(p), md | (p & 1) << 2);
         end
      end
      // pair 2 fans out channel 4 now; seven-bit pattern, inverted
      wch(4, R_PRBS_GEN, 32'hc);
      lfsr = PRBS_SEED;
      @(posedge clk);
      for (int k = 0; k < 40; k++) begin
         @(posedge clk);
         chk("prbs_tx", {31'h0, ~(lfsr[6] ^ lfsr[5])}, {31'h0, tx[4]});
         lfsr = {lfsr[29:0], lfsr[6] ^ lfsr[5]};
      end
      wch(4, R_PRBS_GEN, 32'h0);
      rnd_en <= 1'b1;
      wch(7, R_PRBS_CHK, 32'h19);
      repeat (400) @(posedge clk);
      rdv(ca(7, R_PRBS_ERR), (1 << EW) - 1);
      rdv(ca(7, R_PRBS_CHK), 32'h19);
      // zeros keep a filled checker error free, so a clear must leave zero
      rnd_en <= 1'b0;
      word <= '0;
      repeat (50) @(posedge clk);
      wch(7, R_PRBS_CHK, 32'h1b);
      rdv(ca(7, R_PRBS_ERR), 32'h0);
      rdv(ca(7, R_PRBS_CHK), 32'h19);
      // steady ones on channel 7 miss the pattern nearly every cycle
      word <= 8'h80;
      repeat (80) @(posedge clk);
      rdv(ca(7, R_PRBS_ERR), (1 << EW) - 1);
      wch(7, R_PRBS_CHK, 32'h1d);
      rdv(ca(7, R_PRBS_ERR), 32'h0);
      rdv(ca(7, R_PRBS_CHK), 32'h19);
      repeat (80) @(posedge clk);
      wch(7, R_PRBS_CHK, 32'h0);
      rdv(ca(7, R_PRBS_ERR), 32'h0);
      rdv(ca(7, R_PRBS_CHK), 32'h0);
      sd <= NCH'($urandom);
      lk <= NCH'($urandom);
      repeat (8) @(posedge clk);
      for (int k = 0; k < NCH; k++) rdv(ca(k, R_STATUS), {30'h0, lk[k], sd[k]});
      end_sim();
   end
endmodule
`default_nettype wire
